// [hw/aux_pump_pkg.sv]
package aux_pump_pkg;
  // frequencies in units of 0.1 Hz
  localparam int          FREQ_W          = 16;
  localparam logic [15:0] ACT_LEVEL_RESET = 16'h01f4; // 50.0 Hz
  localparam logic [15:0] HYST_RESET      = 16'h000a; // 1.0 Hz
  localparam int          NUM_MOTORS      = 3;
  localparam int          NUM_RELAYS      = 7;        // relays 6..12
  localparam logic [7:0]  SEL_AUX_LINE    = 8'h58;    // 88
  localparam logic [7:0]  SEL_M1_INV      = 8'ha0;    // 160
  localparam logic [7:0]  SEL_M3_MAINS    = 8'ha5;    // 165
  localparam logic [7:0]  SEL_RESET       = 8'h00;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_ACT_LEVEL   = 8'h04;
  localparam logic [7:0]  OFS_HYST        = 8'h08;
  localparam logic [7:0]  OFS_MODE        = 8'h0c;
  localparam logic [7:0]  OFS_STATUS      = 8'h10;
  localparam logic [7:0]  OFS_SEL_BASE    = 8'h20;
  localparam logic [7:0]  OFS_SEL_LAST    = 8'h38;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// [hw/aux_cfg_if.sv]
`timescale 1ns/100ps
interface aux_cfg_if;
  import aux_pump_pkg::*;
  logic [15:0] actLevel;
  logic [15:0] hystWidth;
  logic [23:0] motorMode;   // three 8-bit mode settings
  logic [2:0]  enAssigned;  // enable input assigned per motor
  logic [55:0] relaySel;    // seven 8-bit selectors, relay 6 low
  logic        auxLine;
  logic [2:0]  allMask;
  modport regs (output actLevel, hystWidth, motorMode, enAssigned, relaySel,
                input auxLine, allMask);
  modport core (input actLevel, hystWidth, motorMode, enAssigned, relaySel,
                output auxLine, allMask);
endinterface

// [hw/aux_pump_regs.sv]
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module aux_pump_regs
  import aux_pump_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  aux_cfg_if.regs          cfg
);
  logic [7:0]  awAddr_q;
  logic        awHave_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wHave_q;
  logic [15:0] act_q;
  logic [15:0] hyst_q;
  logic [23:0] mode_q;
  logic [2:0]  assigned_q;
  logic [55:0] sel_q;
  logic        doWrite;
  logic        wrHit;
  logic        rdHit;
  logic [31:0] rdVal;
  logic [2:0]  wrSelIdx;
  logic [2:0]  rdSelIdx;

  // one write and one read in flight; address and data taken in any order
  assign awready = !awHave_q && !bvalid;
  assign wready  = !wHave_q && !bvalid;
  assign arready = !rvalid;
  assign doWrite = awHave_q && wHave_q && !bvalid;
  assign wrSelIdx = 3'((awAddr_q - OFS_SEL_BASE) >> 2);
  assign rdSelIdx = 3'((araddr - OFS_SEL_BASE) >> 2);
  assign wrHit = (awAddr_q == OFS_CTRL) || (awAddr_q == OFS_ACT_LEVEL)
              || (awAddr_q == OFS_HYST) || (awAddr_q == OFS_MODE)
              || (awAddr_q >= OFS_SEL_BASE && awAddr_q <= OFS_SEL_LAST
                  && awAddr_q[1:0] == 2'b00);

  // read decode, status is the only read-only word
  always_comb
  begin
    rdHit = 1'b1;
    rdVal = 32'h0;
    if (araddr == OFS_CTRL)
      rdVal = {29'h0, assigned_q};
    else if (araddr == OFS_ACT_LEVEL)
      rdVal = {16'h0, act_q};
    else if (araddr == OFS_HYST)
      rdVal = {16'h0, hyst_q};
    else if (araddr == OFS_MODE)
      rdVal = {8'h0, mode_q};
    else if (araddr == OFS_STATUS)
      rdVal = {28'h0, cfg.allMask, cfg.auxLine};
    else if (araddr >= OFS_SEL_BASE && araddr <= OFS_SEL_LAST && araddr[1:0] == 2'b00)
      rdVal = {24'h0, sel_q[rdSelIdx*8 +: 8]};
    else
      rdHit = 1'b0;
  end

  // write channel capture and response
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awAddr_q <= 8'h0;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite)
      begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // configuration storage, byte lanes honoured
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      act_q      <= ACT_LEVEL_RESET;
      hyst_q     <= HYST_RESET;
      mode_q     <= {MODE_RESET, MODE_RESET, MODE_RESET};
      assigned_q <= 3'h0;
      sel_q      <= {NUM_RELAYS{SEL_RESET}};
    end
    else if (doWrite && wrHit)
    begin
      if (awAddr_q == OFS_CTRL && wStrb_q[0])
        assigned_q <= wData_q[2:0];
      else if (awAddr_q == OFS_ACT_LEVEL)
      begin
        if (wStrb_q[0]) act_q[7:0]  <= wData_q[7:0];
        if (wStrb_q[1]) act_q[15:8] <= wData_q[15:8];
      end
      else if (awAddr_q == OFS_HYST)
      begin
        if (wStrb_q[0]) hyst_q[7:0]  <= wData_q[7:0];
        if (wStrb_q[1]) hyst_q[15:8] <= wData_q[15:8];
      end
      else if (awAddr_q == OFS_MODE)
      begin
        if (wStrb_q[0]) mode_q[7:0]   <= wData_q[7:0];
        if (wStrb_q[1]) mode_q[15:8]  <= wData_q[15:8];
        if (wStrb_q[2]) mode_q[23:16] <= wData_q[23:16];
      end
      else if (wStrb_q[0])
        sel_q[wrSelIdx*8 +: 8] <= wData_q[7:0];
    end
  end

  // read response
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rdVal;
      rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  assign cfg.actLevel   = act_q;
  assign cfg.hystWidth  = hyst_q;
  assign cfg.motorMode  = mode_q;
  assign cfg.enAssigned = assigned_q;
  assign cfg.relaySel   = sel_q;
endmodule // aux_pump_regs

// [hw/aux_pump_decide.sv]
`timescale 1ns/100ps
module aux_pump_decide
  import aux_pump_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] outFreq,
  input  wire logic [2:0]  motorEnableIn,
  input  wire logic [2:0]  motorActive,
  aux_cfg_if.core          cfg
);
  logic [2:0]  enabled;
  logic        allActive;
  logic        aboveLevel;
  logic        belowOff;
  logic [16:0] offLevel;
  logic        aux_q;
  logic        aux_d;
  logic [2:0]  enabled_q;

  // enable needs input on (if assigned) and nonzero mode
  genvar m;
  generate
    for (m = 0; m < NUM_MOTORS; m++)
    begin : g_en
      assign enabled[m] = (!cfg.enAssigned[m] || motorEnableIn[m])
                        && (cfg.motorMode[m*8 +: 8] != MODE_RESET);
    end
  endgenerate

  // every enabled pump active; an empty set never satisfies this
  assign allActive  = (enabled != 3'h0) && ((enabled & ~motorActive) == 3'h0);
  assign aboveLevel = outFreq > cfg.actLevel;
  // widened so a level below hysteresis sets borrow bit 16 instead of wrapping unseen
  assign offLevel = {1'b0, cfg.actLevel} - {1'b0, cfg.hystWidth};
  // a borrow means the off level sits below zero, which no frequency can reach
  assign belowOff = !offLevel[16] && ({1'b0, outFreq} < offLevel);

  // set on rise above level, hold until below level minus hysteresis
  assign aux_d = !allActive ? 1'b0
               : aboveLevel ? 1'b1
               : belowOff   ? 1'b0
               : aux_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aux_q     <= 1'b0;
      enabled_q <= 3'h0;
    end
    else
    begin
      aux_q     <= aux_d;
      enabled_q <= enabled;
    end
  end

  assign cfg.auxLine = aux_q;
  assign cfg.allMask = enabled_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_freq_high;
    allActive && aboveLevel;
  endsequence

  a_aux_sets_high: assert property (s_freq_high |=> aux_q)
    else $error("aux line not set above level");
  a_aux_needs_all: assert property (!allActive |=> !aux_q)
    else $error("aux line set with inactive pump");
  a_aux_hyst_hold: assert property (aux_q && allActive && !belowOff |=> aux_q)
    else $error("aux line dropped inside hysteresis");
  a_aux_drop_low: assert property (belowOff && !aboveLevel |=> !aux_q)
    else $error("aux line kept below off level");
  a_aux_no_rise: assert property (!aux_q && !aboveLevel |=> !aux_q)
    else $error("aux line rose without level");
  a_mode_zero_off: assert property (cfg.motorMode[7:0] == MODE_RESET |-> !enabled[0])
    else $error("zero-mode motor counted");
  a_enin_gates: assert property (cfg.enAssigned[1] && !motorEnableIn[1] |-> !enabled[1])
    else $error("enable input ignored");
endmodule // aux_pump_decide

// [hw/aux_pump_relay_control.sv]
`timescale 1ns/100ps
// Summary of operation
// - relay 12 carries the auxiliary-pump line when its selector is 88.
// - aux line comes on only when all enabled pumps are active and frequency is above level.
// - a pump's enable input counts only when assigned; then it must be on.
// - a pump is enabled only while its mode setting is nonzero, together with rule 3.
// - activation level resets to 50.0 Hz.
// - hysteresis width resets to 1.0 Hz.
// - selectors accept codes 160 to 165 for motor inverter and mains signals.
// - the extra pump should leave the mains before the regulated one, never together; here its relay drops one cycle after the motor relay.
// - the extra pump joins only once the regulated pumps are on mains and frequency is high; the code also counts a pump on inverter as active.
module aux_pump_relay_control
  import aux_pump_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [15:0] outFreq,
  input  wire logic [2:0]  motorEnableIn,
  input  wire logic [2:0]  motorInverterDriven,
  input  wire logic [2:0]  motorMainsDriven,
  output logic [6:0]       relayOut
);
  aux_cfg_if cfg ();
  logic [2:0] motorActive;
  logic [6:0] relay_d;
  logic [6:0] relay_q;

  // active means on inverter or on mains
  assign motorActive = motorInverterDriven | motorMainsDriven;

  aux_pump_regs u_regs (
    .clk     (clk),
    .rst_b   (rst_b),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .cfg     (cfg.regs)
  );

  aux_pump_decide u_decide (
    .clk           (clk),
    .rst_b         (rst_b),
    .outFreq       (outFreq),
    .motorEnableIn (motorEnableIn),
    .motorActive   (motorActive),
    .cfg           (cfg.core)
  );

  // each relay maps its selector code; unknown codes give off
  genvar r;
  generate
    for (r = 0; r < NUM_RELAYS; r++)
    begin : g_relay
      logic [7:0] sel;
      logic [7:0] ofs;
      logic       motorSig;
      assign sel = cfg.relaySel[r*8 +: 8];
      assign ofs = sel - SEL_M1_INV;
      assign motorSig = ofs[0] ? motorMainsDriven[ofs[2:1]]
                               : motorInverterDriven[ofs[2:1]];
      assign relay_d[r] = (sel == SEL_AUX_LINE) ? cfg.auxLine
                        : (sel >= SEL_M1_INV && sel <= SEL_M3_MAINS) ? motorSig
                        : 1'b0;
    end
  endgenerate

  // equal latency on every relay; the aux line's own register makes the extra pump drop one cycle after a motor relay
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      relay_q <= 7'h0;
    else
      relay_q <= relay_d;
  end

  assign relayOut = relay_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_relay12_aux: assert property (cfg.relaySel[55:48] == SEL_AUX_LINE |=> relayOut[6] == $past(cfg.auxLine))
    else $error("relay 12 not following aux line");
  a_relay6_code: assert property (cfg.relaySel[7:0] == SEL_M1_INV |=> relayOut[0] == $past(motorInverterDriven[0]))
    else $error("relay 6 wrong motor signal");
  a_relay_mains3: assert property (cfg.relaySel[15:8] == SEL_M3_MAINS |=> relayOut[1] == $past(motorMainsDriven[2]))
    else $error("relay 7 wrong mains signal");
endmodule // aux_pump_relay_control

// [tb/relay_contactor_model.sv]
`timescale 1ns/100ps
// contactor bank on relays 6..12; pull-in and drop-out lag the coil
module relay_contactor_model
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [6:0] coil,
  output logic [6:0]      closed_q
);
  logic [6:0] stage_q;

  // equal two-cycle lag on every contactor, so contactors open in the same order as their coils
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_q  <= 7'h00;
      closed_q <= 7'h00;
    end
    else
    begin
      stage_q  <= coil;
      closed_q <= stage_q;
    end
  end
endmodule // relay_contactor_model

// [tb/test_aux_pump_relay_control.sv]
`timescale 1ns/100ps
module test_aux_pump_relay_control;
  import aux_pump_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire         awready;
  wire         wready;
  wire         bvalid;
  wire         arready;
  wire         rvalid;
  wire  [1:0]  bresp;
  wire  [1:0]  rresp;
  wire  [31:0] rdata;
  logic [15:0] outFreq;
  logic [2:0]  motorEnableIn;
  logic [2:0]  motorInverterDriven;
  logic [2:0]  motorMainsDriven;
  wire  [6:0]  relayOut;
  wire  [6:0]  contactorClosed;
  int          n_errors;
  int          total_checks;
  int          seed;
  // bench copy of the configuration and the expected hysteresis state
  logic [15:0] lvl;
  logic [15:0] hyst;
  logic [2:0]  enAsg;
  logic [2:0]  modeNz;
  logic [55:0] sel;
  logic        auxExp;
  logic [1:0]  resp;
  logic [31:0] rd;

  aux_pump_relay_control i_aux_pump_relay_control (.clk(clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .outFreq(outFreq), .motorEnableIn(motorEnableIn),
    .motorInverterDriven(motorInverterDriven), .motorMainsDriven(motorMainsDriven),
    .relayOut(relayOut));
  relay_contactor_model i_relay_contactor_model (.clk(clk), .rst_b(rst_b), .coil(relayOut),
    .closed_q(contactorClosed));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    @(posedge clk);
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
      if (awready && !aw)
      begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w)
      begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar;
    @(posedge clk);
    ar = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
      if (arready && !ar)
      begin
        ar = 1;
        arvalid <= 1'b0;
      end
    end
  endtask

  // expected relay pattern from the selector codes
  function automatic logic [6:0] relays(input logic aux, input logic [2:0] inv,
                                        input logic [2:0] mns);
    logic [7:0] c;
    relays = 7'h00;
    for (int k = 0; k < 7; k++)
    begin
      c = sel[8*k +: 8];
      if (c == SEL_AUX_LINE)
        relays[k] = aux;
      else if (c >= SEL_M1_INV && c <= SEL_M3_MAINS)
        relays[k] = c[0] ? mns[(c - SEL_M1_INV) >> 1] : inv[(c - SEL_M1_INV) >> 1];
    end
  endfunction

  task automatic step(input logic [15:0] f, input logic [2:0] act, input logic [2:0] en);
    logic [2:0] mns;
    logic [2:0] mask;
    logic [6:0] want;
    mns = 3'($random(seed));
    outFreq <= f;
    motorMainsDriven <= act & mns;
    motorInverterDriven <= act & ~mns;
    motorEnableIn <= en;
    repeat (3) @(posedge clk);
    mask = modeNz & (~enAsg | en);
    if (mask == 3'b000 || (mask & act) != mask)
      auxExp = 0;
    else if (f > lvl)
      auxExp = 1;
    else if (lvl >= hyst && f < lvl - hyst)
      auxExp = 0;
    want = relays(auxExp, act & ~mns, act & mns);
    check(relayOut, want, "relays");
    axiRead(OFS_STATUS, rd, resp);
    check(rd[3:0], {mask, auxExp}, "status");
    check(contactorClosed, want, "contactors");
  endtask

  // park the frequency low so the aux line is off while registers change
  task automatic setup(input logic [2:0] ea, input logic [23:0] m, input logic [15:0] l,
                        input logic [15:0] h);
    outFreq <= 16'h0000;
    auxExp = 0;
    enAsg = ea;
    modeNz = {|m[23:16], |m[15:8], |m[7:0]};
    lvl = l;
    hyst = h;
    axiWrite(OFS_CTRL, 32'(ea), resp);
    axiWrite(OFS_MODE, 32'(m), resp);
    axiWrite(OFS_ACT_LEVEL, 32'(l), resp);
    axiWrite(OFS_HYST, 32'(h), resp);
    for (int k = 0; k < 7; k++)
      axiWrite(OFS_SEL_BASE + 8'(4 * k), 32'(sel[8*k +: 8]), resp);
    check(resp, RESP_OKAY, "select write");
    axiRead(OFS_ACT_LEVEL, rd, resp);
    check(rd, 32'(l), "level readback");
  endtask

  // threshold corners first, then random traffic
  task automatic runSteps(input int n);
    logic [15:0] cor [5];
    cor = '{lvl + 16'd1, lvl - hyst, lvl, lvl - hyst - 16'd1, lvl};
    for (int i = 0; i < 5; i++)
      step(cor[i], 3'b111, 3'b111);
    for (int i = 0; i < n; i++)
      step(16'(300 + ($random(seed) & 511)),
           ($random(seed) & 3) ? 3'b111 : 3'($random(seed)),
           ($random(seed) & 1) ? 3'b111 : 3'($random(seed)));
    $display("test random block done");
  endtask

  initial
  begin
    seed = 71;
    n_errors = 0;
    total_checks = 0;
    rst_b = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'h0;
    outFreq = 16'h0000;
    {motorEnableIn, motorInverterDriven, motorMainsDriven} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check(relayOut, 7'h00, "reset relays");
    axiRead(OFS_ACT_LEVEL, rd, resp);
    check(rd, 32'h1f4, "level default");
    axiRead(OFS_HYST, rd, resp);
    check(rd, 32'h00a, "hyst default");
    axiRead(8'h14, rd, resp);
    check(resp, RESP_SLVERR, "unmapped read");
    axiWrite(8'h40, 32'h5a, resp);
    check(resp, RESP_SLVERR, "unmapped write");
    $display("test reset and map done");
    for (int k = 0; k < 6; k++)
      sel[8*k +: 8] = SEL_M1_INV + 8'(k);
    sel[55:48] = SEL_AUX_LINE;
    setup(3'b000, 24'h010101, 16'd470, 16'd150);
    runSteps(40);
    // reset in mid-run drops every relay at once; registers then need reloading
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check(relayOut, 7'h00, "relays in reset");
    rst_b <= 1'b1;
    @(posedge clk);
    axiRead(OFS_HYST, rd, resp);
    check(rd, 32'(HYST_RESET), "hyst after reset");
    sel[7:0] = SEL_AUX_LINE;
    sel[15:8] = SEL_M3_MAINS;
    sel[23:16] = 8'ha6;
    setup(3'b011, 24'h000201, 16'(400 + ($random(seed) & 255)), 16'($random(seed) & 127));
    runSteps(40);
    // level below hysteresis: the off threshold is out of reach while pumps run
    setup(3'b000, 24'h010101, 16'd20, 16'd40);
    runSteps(8);
    conclude();
  end

  // generous bound on the whole run
  initial
  begin
    #500000;
    check(1, 0, "watchdog");
    conclude();
  end
endmodule // test_aux_pump_relay_control
